// [card_model.sv]
// Card side model: answers host card accesses with start and done pulses
`timescale 1ns/10ps
`default_nettype none
module card_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Host access request and cycle length
  input wire logic access,
  input wire logic [3:0] len,
  // Card cycle events
  output logic card_cycle_start,
  output logic card_cycle_done
);
  logic busy_reg;
  logic [3:0] cnt_reg;

  // Only a host access opens a cycle, never an interrupt
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      card_cycle_start <= 1'b0;
      card_cycle_done <= 1'b0;
    end
    else
    begin
      card_cycle_start <= access && !busy_reg;
      card_cycle_done <= busy_reg && cnt_reg == 4'h0;
      if (access && !busy_reg)
      begin
        busy_reg <= 1'b1;
        cnt_reg <= len;
      end
      else if (busy_reg && cnt_reg == 4'h0)
        busy_reg <= 1'b0;
      else if (busy_reg)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [card_sleep_ctrl.sv]
// Card output enable control for power-down mode
`timescale 1ns/10ps
`default_nettype none
module card_sleep_ctrl
  import sgc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic sleep_en,
  input wire logic card_cycle_start,
  input wire logic card_cycle_done,
  // Card output enable
  output logic card_out_en
);

  card_state_t state_reg;
  card_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CARD_AWAKE:
      begin
        if (sleep_en)
          state_next = card_cycle_start ? CARD_ACTIVE : CARD_HIZ;
      end
      CARD_HIZ:
      begin
        if (!sleep_en)
          state_next = CARD_AWAKE;
        else if (card_cycle_start)
          state_next = CARD_ACTIVE;
      end
      CARD_ACTIVE:
      begin
        // Back-to-back cycle keeps outputs driven
        if (card_cycle_done && !card_cycle_start)
          state_next = sleep_en ? CARD_HIZ : CARD_AWAKE;
      end
      default:
        state_next = CARD_AWAKE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      state_reg <= CARD_AWAKE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      card_out_en <= 1'b1;
    else
      card_out_en <= (state_next != CARD_HIZ);
  end

  a_sleep_hiz: assert property (@(posedge mclk) disable iff (!resetn)
    (sleep_en && state_reg == CARD_HIZ && !card_cycle_start) |=> !card_out_en)
    else $error("card outputs driven while asleep and idle");

  a_cycle_wakes: assert property (@(posedge mclk) disable iff (!resetn)
    card_cycle_start |=> card_out_en)
    else $error("card access did not wake outputs");

  a_done_sleeps: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CARD_ACTIVE && card_cycle_done && !card_cycle_start && sleep_en)
      |=> !card_out_en)
    else $error("outputs not released after cycle");

endmodule
`default_nettype wire

// [sgc_pkg.sv]
// Package for the socket global control register block
package sgc_pkg;

  // Register offset within the socket compatibility space
  localparam logic [7:0] SGC_OFFSET = 8'h1e;
  localparam logic [7:0] SGC_RESET = 8'h00;

  // Field positions
  localparam int SLEEP_BIT = 0;
  localparam int CSC_LEVEL_BIT = 1;
  localparam int WRITEBACK_BIT = 2;
  localparam int FIRST_LEVEL_BIT = 3;
  localparam int SECOND_LEVEL_BIT = 4;
  localparam logic [7:0] WRITABLE_MASK = 8'h1f;

  // Card-detect change flag position in the status-change register
  localparam int CD_CHANGE_BIT = 3;

  // Host interrupt modes
  typedef enum logic {
    IRQ_EDGE = 1'b0,
    IRQ_LEVEL = 1'b1
  } irq_mode_t;

  // Register fields as seen by the rest of the socket
  typedef struct packed {
    logic [2:0] unused_bits;
    irq_mode_t second_card_irq_level_sel;
    irq_mode_t first_card_irq_level_sel;
    logic flag_clear_by_writeback;
    irq_mode_t status_change_irq_level_sel;
    logic socket_sleep_enable;
  } global_ctrl_t;

  // Register access from the compatibility register space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // Card sleep controller states
  typedef enum logic [1:0] {
    CARD_HIZ = 2'b00,
    CARD_ACTIVE = 2'b01,
    CARD_AWAKE = 2'b10
  } card_state_t;

endpackage

// [socket_global_control.sv]
// Socket global control register with power-down card interface control
//
// Functional notes
// - Bits 7 to 5 read zero, ignore writes
// - Bit 4: second card irq edge/level
// - Bit 3: first card irq edge/level
// - Bit 2: flags clear on read or writeback
// - Bit 1: status-change irq edge/level
// - Bit 0 enables socket power-down mode
// - Asleep: card outputs high-Z until cycle
// - Asleep: outputs back to high-Z after cycle
// - Asleep: interrupts still accepted
// - Only card access wakes, not interrupts
// - Writeback clear of detect clears soft request
// - Register cleared only by global reset
`timescale 1ns/10ps
`default_nettype none
module socket_global_control
  import sgc_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic resetn,
  input wire logic global_reset_n,
  // Register access
  input wire reg_access_t reg_acc,
  output logic [7:0] rdata,
  // Status-change register access strobes
  input wire logic csc_read,
  input wire logic csc_write,
  input wire logic [7:0] csc_wdata,
  input wire logic soft_detect_request,
  // Card interrupt sources
  input wire logic first_card_irq,
  input wire logic second_card_irq,
  input wire logic status_change_irq,
  // Card cycle events
  input wire logic card_cycle_start,
  input wire logic card_cycle_done,
  // Outputs
  output global_ctrl_t ctrl,
  output logic [7:0] status_change_flag_clear,
  output logic soft_detect_clear,
  output logic first_card_irq_out,
  output logic second_card_irq_out,
  output logic status_change_irq_out,
  output logic card_out_en
);

  //////////////////////////////////////////////////////////////////////////////
  global_ctrl_t ctrl_reg;
  logic sel_wr;
  logic sel_rd;
  logic [2:0] irq_src;
  logic [2:0] irq_mode;
  logic [2:0] irq_prev_reg;
  logic [2:0] irq_out_next;

  assign sel_wr = reg_acc.wr && (reg_acc.addr == SGC_OFFSET);
  assign sel_rd = reg_acc.rd && (reg_acc.addr == SGC_OFFSET);
  assign ctrl = ctrl_reg;

  // Only the global reset clears this register
  always_ff @(posedge mclk)
  begin
    if (!global_reset_n)
      ctrl_reg <= global_ctrl_t'(SGC_RESET);
    else if (sel_wr)
      ctrl_reg <= global_ctrl_t'(reg_acc.wdata & WRITABLE_MASK);
  end

  // Read data, upper bits forced to zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (sel_rd)
      rdata <= 8'(ctrl_reg) & WRITABLE_MASK;
    else
      rdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status-change flag clear strobes
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      status_change_flag_clear <= 8'h00;
    else if (ctrl_reg.flag_clear_by_writeback)
      status_change_flag_clear <= csc_write ? csc_wdata : 8'h00;
    else
      status_change_flag_clear <= csc_read ? 8'hff : 8'h00;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      soft_detect_clear <= 1'b0;
    else
      soft_detect_clear <= ctrl_reg.flag_clear_by_writeback && csc_write
        && csc_wdata[CD_CHANGE_BIT] && soft_detect_request;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host interrupt signalling, accepted regardless of power-down
  assign irq_src = {status_change_irq, second_card_irq, first_card_irq};
  assign irq_mode = {ctrl_reg.status_change_irq_level_sel, ctrl_reg.second_card_irq_level_sel,
    ctrl_reg.first_card_irq_level_sel};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_irq
      // Level passes through, edge gives a one-cycle pulse on a rising source
      assign irq_out_next[i] = irq_mode[i] ? irq_src[i]
        : (irq_src[i] && !irq_prev_reg[i]);
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      irq_prev_reg <= 3'h0;
      first_card_irq_out <= 1'b0;
      second_card_irq_out <= 1'b0;
      status_change_irq_out <= 1'b0;
    end
    else
    begin
      irq_prev_reg <= irq_src;
      first_card_irq_out <= irq_out_next[0];
      second_card_irq_out <= irq_out_next[1];
      status_change_irq_out <= irq_out_next[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts never reach the wake logic
  card_sleep_ctrl u_sleep (
    .mclk(mclk),
    .resetn(resetn),
    .sleep_en(ctrl_reg.socket_sleep_enable),
    .card_cycle_start(card_cycle_start),
    .card_cycle_done(card_cycle_done),
    .card_out_en(card_out_en)
  );

  //////////////////////////////////////////////////////////////////////////////
  a_upper_zero: assert property (@(posedge mclk) disable iff (!global_reset_n)
    rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_write_store: assert property (@(posedge mclk) disable iff (!global_reset_n)
    sel_wr |=> ctrl_reg == global_ctrl_t'($past(reg_acc.wdata) & WRITABLE_MASK))
    else $error("write did not store");

  a_global_reset_n_clear: assert property (@(posedge mclk)
    !global_reset_n |=> ctrl_reg == global_ctrl_t'(SGC_RESET))
    else $error("global reset did not clear");

  a_ctrl_holds: assert property (@(posedge mclk) disable iff (!global_reset_n)
    (!sel_wr && !resetn) |=> $stable(ctrl_reg))
    else $error("other reset changed register");

  a_read_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (csc_read && !ctrl_reg.flag_clear_by_writeback) |=> status_change_flag_clear == 8'hff)
    else $error("read did not clear flags");

  a_wb_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl_reg.flag_clear_by_writeback && !csc_write) |=> status_change_flag_clear == 8'h00)
    else $error("flags cleared without writeback");

  a_soft_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl_reg.flag_clear_by_writeback && csc_write && csc_wdata[CD_CHANGE_BIT]
      && soft_detect_request) |=> soft_detect_clear)
    else $error("soft detect request not cleared");

  a_level_irq: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl_reg.status_change_irq_level_sel == IRQ_LEVEL && status_change_irq)
      |=> status_change_irq_out)
    else $error("level status irq missing");

  a_edge_irq: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl_reg.first_card_irq_level_sel == IRQ_EDGE && first_card_irq
      && $past(first_card_irq)) |=> !first_card_irq_out)
    else $error("edge irq not a pulse");

  a_irq_no_wake: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl_reg.socket_sleep_enable && !card_out_en && !card_cycle_start && second_card_irq)
      |=> !card_out_en)
    else $error("interrupt woke card interface");

endmodule
`default_nettype wire

// [socket_global_control_tb.sv]
// Self-checking testbench for the socket global control register
`timescale 1ns/10ps
`default_nettype none
module socket_global_control_tb
  import sgc_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic global_reset_n = 1'b0;
  reg_access_t reg_acc = '0;
  logic csc_read = 1'b0;
  logic csc_write = 1'b0;
  logic [7:0] csc_wdata = 8'h00;
  logic soft_detect_request = 1'b0;
  logic [2:0] irq_in = 3'h0;
  logic access = 1'b0;
  logic [3:0] len = 4'h0;
  wire [2:0] irq_out;
  wire card_cycle_start;
  wire card_cycle_done;
  wire card_out_en;
  wire soft_detect_clear;
  wire [7:0] rdata;
  wire [7:0] flag_clear;
  global_ctrl_t ctrl;
  int err_total = 0;
  int n_checks = 0;
  int lvl_bit[3] = '{FIRST_LEVEL_BIT, SECOND_LEVEL_BIT, CSC_LEVEL_BIT};
  logic [31:0] seed = 32'h3535cd91;
  logic [7:0] d;
  int k;

  always #2.5 mclk = ~mclk;

  socket_global_control DUT (.mclk(mclk), .resetn(resetn), .global_reset_n(global_reset_n),
    .reg_acc(reg_acc), .rdata(rdata), .csc_read(csc_read), .csc_write(csc_write),
    .csc_wdata(csc_wdata), .soft_detect_request(soft_detect_request),
    .first_card_irq(irq_in[0]), .second_card_irq(irq_in[1]), .status_change_irq(irq_in[2]),
    .card_cycle_start(card_cycle_start), .card_cycle_done(card_cycle_done), .ctrl(ctrl),
    .status_change_flag_clear(flag_clear), .soft_detect_clear(soft_detect_clear),
    .first_card_irq_out(irq_out[0]), .second_card_irq_out(irq_out[1]),
    .status_change_irq_out(irq_out[2]), .card_out_en(card_out_en));

  card_model card (.mclk(mclk), .resetn(resetn), .access(access), .len(len),
    .card_cycle_start(card_cycle_start), .card_cycle_done(card_cycle_done));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reserved bits read zero
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
    return {3'h0, v[4:0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    reg_acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(negedge mclk);
    reg_acc.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge mclk);
    reg_acc.rd <= 1'b0;
    check(rdata, exp);
  endtask

  task automatic status_change_flags(input logic r, input logic w);
    @(negedge mclk);
    csc_read <= r;
    csc_write <= w;
    @(negedge mclk);
    csc_read <= 1'b0;
    csc_write <= 1'b0;
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    err_total++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    resetn <= 1'b1;
    global_reset_n <= 1'b1;
    @(negedge mclk);
    check(ctrl, SGC_RESET);
    rd(SGC_OFFSET, 8'h00);
    // Corners then random values
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'hff : (i == 1) ? 8'he0 : seed[7:0];
      wr(SGC_OFFSET, d);
      check(ctrl, exp_ctrl(d));
      rd(SGC_OFFSET, exp_ctrl(d));
    end
    wr(8'h1f, 8'h00);
    rd(8'h1f, 8'h00);
    check(ctrl, exp_ctrl(d));
    wr(SGC_OFFSET, 8'h1f);
    @(negedge mclk);
    resetn <= 1'b0;
    repeat (2) @(negedge mclk);
    resetn <= 1'b1;
    check(ctrl, 8'h1f);
    global_reset_n <= 1'b0;
    @(negedge mclk);
    global_reset_n <= 1'b1;
    check(ctrl, 8'h00);
    // Flag clearing in both modes
    for (int m = 0; m < 2; m++)
    begin
      wr(SGC_OFFSET, m[0] ? 8'h04 : 8'h00);
      status_change_flags(1'b1, 1'b0);
      check(flag_clear, m[0] ? 8'h00 : 8'hff);
      for (int j = 0; j < 4; j++)
      begin
        seed = lfsr(seed);
        d = (j == 0) ? 8'h08 : seed[7:0];
        csc_wdata <= d;
        soft_detect_request <= (j == 0) || seed[9];
        status_change_flags(1'b0, 1'b1);
        check(flag_clear, m[0] ? d : 8'h00);
        check(8'(soft_detect_clear), 8'(m[0] & d[3] & ((j == 0) || seed[9])));
      end
    end
    // Interrupt signalling per source and mode
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 3; i++)
      begin
        wr(SGC_OFFSET, m[0] ? 8'(1 << lvl_bit[i]) : 8'h00);
        irq_in[i] <= 1'b1;
        @(negedge mclk);
        check(8'(irq_out[i]), 8'h01);
        @(negedge mclk);
        check(8'(irq_out[i]), 8'(m[0]));
        irq_in[i] <= 1'b0;
        @(negedge mclk);
        check(8'(irq_out[i]), 8'h00);
      end
    // Sleep mode: interrupts do not wake, card accesses do
    wr(SGC_OFFSET, 8'h01);
    @(negedge mclk);
    check(8'(card_out_en), 8'h00);
    irq_in <= 3'h7;
    @(negedge mclk);
    check(8'(irq_out), 8'h07);
    repeat (3) @(negedge mclk);
    check(8'(card_out_en), 8'h00);
    irq_in <= 3'h0;
    for (int n = 0; n < 2; n++)
    begin
      len <= n[0] ? 4'h5 : 4'h0;
      access <= 1'b1;
      k = 0;
      while (card_cycle_start !== 1'b1 && k < 10)
      begin
        @(negedge mclk);
        k++;
      end
      check(8'(card_cycle_start), 8'h01);
      access <= 1'b0;
      @(negedge mclk);
      check(8'(card_out_en), 8'h01);
      while (card_cycle_done !== 1'b1 && k < 40)
      begin
        @(negedge mclk);
        k++;
      end
      check(8'(card_cycle_done), 8'h01);
      @(negedge mclk);
      check(8'(card_out_en), 8'h00);
    end
    wr(SGC_OFFSET, 8'h00);
    @(negedge mclk);
    check(8'(card_out_en), 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
